// ---- rhp_pkg.sv ----
`default_nettype none

package rhp_pkg;

    // Clock and protocol times
    localparam int CLK_PERIOD_NS  = 40;
    localparam int RST_TIME_MS    = 10;
    localparam int RSM_TIME_MS    = 20;
    localparam int RSYNC_TIME_MS  = 3;
    localparam int EOP_TIME_NS    = 1333;
    localparam int RST_CYC        = RST_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int RSM_CYC        = RSM_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int RSYNC_CYC      = RSYNC_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int EOP_CYC        = (EOP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Command codes
    localparam logic [7:0] CMD_RD_P1 = 8'h15;
    localparam logic [7:0] CMD_RD_P2 = 8'h16;
    localparam logic [7:0] CMD_WR_P1 = 8'h95;
    localparam logic [7:0] CMD_WR_P2 = 8'h96;

    // Status bits, lower word
    localparam int B_ATTACHED   = 0;
    localparam int B_ENABLED    = 1;
    localparam int B_SUSPENDED  = 2;
    localparam int B_OCI        = 3;
    localparam int B_RESET      = 4;
    localparam int B_POWER      = 8;
    localparam int B_SLOW       = 9;
    // Change flags, upper word
    localparam int B_ATTACH_CHG  = 16;
    localparam int B_DISABLE_CHG = 17;
    localparam int B_RESUME_DONE = 18;
    localparam int B_OC_CHG      = 19;
    localparam int B_RESET_DONE  = 20;
    // Write-one command bits of the lower word
    localparam int W_CLR_ENABLE  = 0;
    localparam int W_SET_ENABLE  = 1;
    localparam int W_SET_SUSPEND = 2;
    localparam int W_CLR_SUSPEND = 3;
    localparam int W_SET_RESET   = 4;
    localparam int W_SET_POWER   = 8;
    localparam int W_CLR_POWER   = 9;

    localparam logic [31:0] REG_RESET = 32'h0000_0000;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_RESUME = 3'h1,
        ST_EOP    = 3'h3,
        ST_RESYNC = 3'h2,
        ST_RESET  = 3'h4
    } rhp_state_t;

endpackage

`default_nettype wire

// ---- rhp_port_flags.sv ----
// Operation
// - Set reset-done flag when the 10 ms port reset ends.
// - Change flags clear on a written one (resume-done also when reset ends); zero leaves them.
// - Set overcurrent change flag whenever the port overcurrent indicator changes.
// - Set resume-done flag after 20 ms resume, low-speed EOP, 3 ms resync.
// - Clear resume-done flag whenever reset-done flag becomes set.
// - Set disable change flag only when hardware clears the enabled status.
// - Read codes 15h/16h, write codes 95h/96h for ports 1/2.
// - Status in lower 16 bits, change flags in upper 16 bits.
// - Set attach change on attach, detach, or request while unattached.
`timescale 1ns/10ps
`default_nettype none

module rhp_port_flags #(
    parameter int unsigned P_RST_CYC   = rhp_pkg::RST_CYC,
    parameter int unsigned P_RSM_CYC   = rhp_pkg::RSM_CYC,
    parameter int unsigned P_RSYNC_CYC = rhp_pkg::RSYNC_CYC
) (
    input  wire logic        i_sys_clk,        // System clock, 25 MHz
    input  wire logic        i_rst,            // Async reset, active high
    input  wire logic        i_cmd_valid,      // Command strobe
    input  wire logic [7:0]  i_cmd_code,       // Command code
    input  wire logic [31:0] i_cmd_wdata,      // Write data
    output logic      [31:0] o_rd_data,        // Read data
    output logic             o_rd_valid,       // Read data valid pulse
    input  wire logic [1:0]  i_attached,       // Device present per port
    input  wire logic [1:0]  i_slow_device,    // Low-speed device per port
    input  wire logic [1:0]  i_overcurrent,    // Overcurrent per port
    input  wire logic [1:0]  i_port_fault,     // Hardware disable event pulse
    input  wire logic [1:0]  i_remote_wake,    // Remote wake-up pulse
    output logic      [1:0]  o_bus_reset,      // Drive reset signalling
    output logic      [1:0]  o_bus_resume,     // Drive resume signalling
    output logic      [1:0]  o_port_power      // Port power switch
);

    localparam int CW = $clog2(P_RSM_CYC > P_RST_CYC ? P_RSM_CYC : P_RST_CYC) + 1;

    // The EOP count shares the timer, so it must fit the width sized by the long phases
    if (P_RST_CYC < 1 || P_RSM_CYC < 1 || P_RSYNC_CYC < 1 || P_RSYNC_CYC > P_RSM_CYC ||
        rhp_pkg::EOP_CYC > (2 ** CW)) begin : g_chk
        $error("rhp_port_flags: timing counts out of range");
    end

    function automatic logic flag_upd(input logic cur, input logic set, input logic clr);
        // Set wins over a clear arriving in the same cycle
        return set | (cur & ~clr);
    endfunction

    logic [1:0]  attached_ff, enabled_ff, suspended_ff, oci_ff, power_ff, slow_ff;
    logic [1:0]  attach_chg_ff, disable_chg_ff, resume_done_ff, oc_chg_ff, reset_done_ff;
    logic [1:0]  bus_reset_ff, bus_resume_ff;
    logic [1:0]  nxt_enabled, nxt_suspended, nxt_power, nxt_slow;
    logic [1:0]  nxt_attach_chg, nxt_disable_chg, nxt_resume_done, nxt_oc_chg, nxt_reset_done;
    logic [1:0]  nxt_bus_reset, nxt_bus_resume;
    logic [31:0] rd_data_ff;
    logic        rd_valid_ff;
    logic [CW-1:0]      tmr_ff  [2];
    logic [CW-1:0]      nxt_tmr [2];
    rhp_pkg::rhp_state_t st_ff  [2];
    rhp_pkg::rhp_state_t nxt_st [2];

    wire  [31:0] wd = i_cmd_wdata;
    logic [31:0] port_word [2];
    wire  [1:0]  wr_hit, rd_hit, blocked_wr, attach_evt, rst_done, rsm_done;
    wire  [1:0]  hw_disable, start_rst, start_rsm;

    assign rd_hit[0] = i_cmd_valid && (i_cmd_code == rhp_pkg::CMD_RD_P1);
    assign rd_hit[1] = i_cmd_valid && (i_cmd_code == rhp_pkg::CMD_RD_P2);
    assign wr_hit[0] = i_cmd_valid && (i_cmd_code == rhp_pkg::CMD_WR_P1);
    assign wr_hit[1] = i_cmd_valid && (i_cmd_code == rhp_pkg::CMD_WR_P2);

    for (genvar p = 0; p < 2; p++) begin : g_ev
        // Requests that need a device are refused when nothing is attached
        assign blocked_wr[p] = wr_hit[p] && !attached_ff[p] &&
            (wd[rhp_pkg::W_SET_RESET] || wd[rhp_pkg::W_SET_ENABLE] ||
             wd[rhp_pkg::W_SET_SUSPEND]);
        assign attach_evt[p] = i_attached[p] != attached_ff[p];
        assign start_rst[p]  = wr_hit[p] && attached_ff[p] && i_attached[p] &&
                               wd[rhp_pkg::W_SET_RESET];
        assign start_rsm[p]  = (st_ff[p] == rhp_pkg::ST_IDLE) && suspended_ff[p] &&
                               i_attached[p] && !start_rst[p] &&
                               (i_remote_wake[p] || (wr_hit[p] && wd[rhp_pkg::W_CLR_SUSPEND]));
        assign rst_done[p]   = (st_ff[p] == rhp_pkg::ST_RESET) && (tmr_ff[p] == '0) &&
                               i_attached[p] && !start_rst[p];
        assign rsm_done[p]   = (st_ff[p] == rhp_pkg::ST_RESYNC) && (tmr_ff[p] == '0) &&
                               i_attached[p] && !start_rst[p];
        // Driver writes never count; only faults and detach count as a hardware disable
        assign hw_disable[p] = enabled_ff[p] && (i_port_fault[p] || !i_attached[p]);
        assign port_word[p]  = {11'h000,
                                reset_done_ff[p], oc_chg_ff[p], resume_done_ff[p],
                                disable_chg_ff[p], attach_chg_ff[p],
                                6'h00, slow_ff[p], power_ff[p],
                                3'h0, bus_reset_ff[p], oci_ff[p], suspended_ff[p],
                                enabled_ff[p], attached_ff[p]};
    end

    always_comb begin
        for (int p = 0; p < 2; p++) begin
            nxt_st[p]  = st_ff[p];
            nxt_tmr[p] = (tmr_ff[p] == '0) ? tmr_ff[p] : tmr_ff[p] - CW'(1);
            case (st_ff[p])
                rhp_pkg::ST_IDLE: begin
                    if (start_rsm[p]) begin
                        nxt_st[p]  = rhp_pkg::ST_RESUME;
                        nxt_tmr[p] = CW'(P_RSM_CYC - 1);
                    end
                end
                rhp_pkg::ST_RESET: begin
                    if (tmr_ff[p] == '0) nxt_st[p] = rhp_pkg::ST_IDLE;
                end
                rhp_pkg::ST_RESUME: begin
                    if (tmr_ff[p] == '0) begin
                        nxt_st[p]  = rhp_pkg::ST_EOP;
                        nxt_tmr[p] = CW'(rhp_pkg::EOP_CYC - 1);
                    end
                end
                rhp_pkg::ST_EOP: begin
                    if (tmr_ff[p] == '0) begin
                        nxt_st[p]  = rhp_pkg::ST_RESYNC;
                        nxt_tmr[p] = CW'(P_RSYNC_CYC - 1);
                    end
                end
                rhp_pkg::ST_RESYNC: begin
                    if (tmr_ff[p] == '0) nxt_st[p] = rhp_pkg::ST_IDLE;
                end
                default: nxt_st[p] = rhp_pkg::ST_IDLE;
            endcase
            // A reset request restarts the port even in the middle of a resume
            if (start_rst[p]) begin
                nxt_st[p]  = rhp_pkg::ST_RESET;
                nxt_tmr[p] = CW'(P_RST_CYC - 1);
            end
            if (!i_attached[p]) nxt_st[p] = rhp_pkg::ST_IDLE;

            nxt_enabled[p] = enabled_ff[p];
            if (hw_disable[p]) nxt_enabled[p] = 1'b0;
            else if (rst_done[p]) nxt_enabled[p] = 1'b1;
            else if (wr_hit[p] && wd[rhp_pkg::W_SET_ENABLE] && attached_ff[p])
                nxt_enabled[p] = 1'b1;
            else if (wr_hit[p] && wd[rhp_pkg::W_CLR_ENABLE]) nxt_enabled[p] = 1'b0;

            nxt_suspended[p] = suspended_ff[p];
            if (!i_attached[p] || start_rst[p] || rsm_done[p]) nxt_suspended[p] = 1'b0;
            else if (wr_hit[p] && wd[rhp_pkg::W_SET_SUSPEND] && enabled_ff[p])
                nxt_suspended[p] = 1'b1;

            nxt_power[p] = power_ff[p];
            if (wr_hit[p] && wd[rhp_pkg::W_SET_POWER]) nxt_power[p] = 1'b1;
            else if (wr_hit[p] && wd[rhp_pkg::W_CLR_POWER]) nxt_power[p] = 1'b0;
            nxt_slow[p] = i_attached[p] & i_slow_device[p];

            nxt_attach_chg[p]  = flag_upd(attach_chg_ff[p], attach_evt[p] | blocked_wr[p],
                                          wr_hit[p] & wd[rhp_pkg::B_ATTACH_CHG]);
            nxt_disable_chg[p] = flag_upd(disable_chg_ff[p], hw_disable[p],
                                          wr_hit[p] & wd[rhp_pkg::B_DISABLE_CHG]);
            nxt_resume_done[p] = flag_upd(resume_done_ff[p], rsm_done[p],
                                          (wr_hit[p] & wd[rhp_pkg::B_RESUME_DONE]) |
                                          rst_done[p]);
            nxt_oc_chg[p]      = flag_upd(oc_chg_ff[p], i_overcurrent[p] ^ oci_ff[p],
                                          wr_hit[p] & wd[rhp_pkg::B_OC_CHG]);
            nxt_reset_done[p]  = flag_upd(reset_done_ff[p], rst_done[p],
                                          wr_hit[p] & wd[rhp_pkg::B_RESET_DONE]);
            nxt_bus_reset[p]   = nxt_st[p] == rhp_pkg::ST_RESET;
            nxt_bus_resume[p]  = nxt_st[p] == rhp_pkg::ST_RESUME;
        end
    end

    // Every per-port flop is indexed by its own port only
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            {attached_ff, enabled_ff, suspended_ff, oci_ff, power_ff, slow_ff} <= '0;
            {attach_chg_ff, disable_chg_ff, resume_done_ff, oc_chg_ff, reset_done_ff} <= '0;
            {bus_reset_ff, bus_resume_ff} <= '0;
            st_ff  <= '{rhp_pkg::ST_IDLE, rhp_pkg::ST_IDLE};
            tmr_ff <= '{'0, '0};
        end else begin
            attached_ff    <= i_attached;
            oci_ff         <= i_overcurrent;
            enabled_ff     <= nxt_enabled;
            suspended_ff   <= nxt_suspended;
            power_ff       <= nxt_power;
            slow_ff        <= nxt_slow;
            attach_chg_ff  <= nxt_attach_chg;
            disable_chg_ff <= nxt_disable_chg;
            resume_done_ff <= nxt_resume_done;
            oc_chg_ff      <= nxt_oc_chg;
            reset_done_ff  <= nxt_reset_done;
            bus_reset_ff   <= nxt_bus_reset;
            bus_resume_ff  <= nxt_bus_resume;
            st_ff          <= nxt_st;
            tmr_ff         <= nxt_tmr;
        end
    end

    // Read data holds until the next read so slow hosts can sample late
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            rd_data_ff  <= rhp_pkg::REG_RESET;
            rd_valid_ff <= 1'b0;
        end else begin
            rd_valid_ff <= |rd_hit;
            if (rd_hit[0]) rd_data_ff <= port_word[0];
            else if (rd_hit[1]) rd_data_ff <= port_word[1];
        end
    end

    assign o_rd_data    = rd_data_ff;
    assign o_rd_valid   = rd_valid_ff;
    assign o_bus_reset  = bus_reset_ff;
    assign o_bus_resume = bus_resume_ff;
    assign o_port_power = power_ff;

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    for (genvar p = 0; p < 2; p++) begin : g_sva
        a_reset_done_end: assert property (
            $rose(reset_done_ff[p]) |->
                $past(st_ff[p] == rhp_pkg::ST_RESET && tmr_ff[p] == '0) && enabled_ff[p])
            else $error("reset-done set outside end of reset");
        a_zero_write_keeps: assert property (
            (wr_hit[p] && !wd[rhp_pkg::B_RESET_DONE] && reset_done_ff[p]) |=> reset_done_ff[p])
            else $error("written zero cleared reset-done flag");
        a_one_write_clears: assert property (
            (wr_hit[p] && wd[rhp_pkg::B_OC_CHG] && i_overcurrent[p] == oci_ff[p])
                |=> !oc_chg_ff[p])
            else $error("written one did not clear overcurrent flag");
        a_oc_change_set: assert property (
            (i_overcurrent[p] != oci_ff[p]) |=> oc_chg_ff[p] && oci_ff[p] == $past(i_overcurrent[p]))
            else $error("overcurrent change not flagged");
        a_resume_seq_end: assert property (
            $rose(resume_done_ff[p]) |->
                $past(st_ff[p] == rhp_pkg::ST_RESYNC) && !suspended_ff[p])
            else $error("resume-done set before full sequence");
        a_resume_cleared: assert property (
            $rose(reset_done_ff[p]) |-> !resume_done_ff[p])
            else $error("resume-done survived reset completion");
        a_disable_hw_only: assert property (
            $rose(disable_chg_ff[p]) |-> $past(enabled_ff[p]) && !enabled_ff[p] &&
                $past(i_port_fault[p] || !i_attached[p]))
            else $error("disable change without hardware disable");
        a_read_word: assert property (
            rd_hit[p] |=> o_rd_valid && o_rd_data == $past(port_word[p]) &&
                o_rd_data[31:21] == 11'h000 && o_rd_data[7:5] == 3'h0)
            else $error("port read returned wrong word");
        a_blocked_req: assert property (
            (wr_hit[p] && wd[rhp_pkg::W_SET_RESET] && !attached_ff[p])
                |=> attach_chg_ff[p] && st_ff[p] != rhp_pkg::ST_RESET)
            else $error("request while unattached not flagged");
        a_port_isolated: assert property (
            $rose(attach_chg_ff[p]) |-> $past(attach_evt[p] || blocked_wr[p]))
            else $error("attach change without own port event");
        c_reset_done: cover property ($rose(reset_done_ff[p]));
        c_resume_done: cover property ($rose(resume_done_ff[p]));
        c_hw_disable: cover property ($rose(disable_chg_ff[p]));
    end

endmodule

`default_nettype wire

// ---- rhp_usb_dev_model.sv ----
`timescale 1ns/10ps
`default_nettype none

// Downstream device seen by both ports; the bench steers plugging and fault events.
module rhp_usb_dev_model #(
    parameter logic [1:0] P_SLOW = 2'h0
) (
    input  wire logic       i_sys_clk,     // System clock
    input  wire logic [1:0] i_plug,        // Bench: device plugged in
    input  wire logic [1:0] i_oc_req,      // Bench: overcurrent present
    input  wire logic [1:0] i_fault_req,   // Bench: one-cycle fault pulse
    input  wire logic [1:0] i_bus_reset,   // Reset signalling seen on the wire
    output logic      [1:0] o_attached,    // Presence to the port
    output logic      [1:0] o_slow_device, // Speed to the port
    output logic      [1:0] o_overcurrent, // Overcurrent to the port
    output logic      [1:0] o_port_fault,  // Fault event to the port
    output logic     [15:0] o_rst_len      // Cycles of the last reset seen on port 1
);
    logic [1:0]  rst_seen_ff;
    logic [15:0] rst_len_ff;

    // Speed is only meaningful while plugged; it reads low otherwise
    assign o_attached    = i_plug;
    assign o_slow_device = i_plug & P_SLOW;
    assign o_overcurrent = i_oc_req;
    assign o_port_fault  = i_fault_req & i_plug;

    always_ff @(posedge i_sys_clk) begin
        rst_seen_ff <= i_bus_reset & i_plug;
        // A fresh reset restarts the count so each reset is measured on its own
        if (i_bus_reset[0] && !rst_seen_ff[0]) begin
            rst_len_ff <= 16'h0001;
        end else if (i_bus_reset[0]) begin
            rst_len_ff <= rst_len_ff + 16'h0001;
        end
    end

    assign o_rst_len = rst_len_ff;
endmodule

`default_nettype wire

// ---- root_hub_port_change_flags_tb.sv ----
`timescale 1ns/10ps
`default_nettype none

module root_hub_port_change_flags_tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cmd_valid = 1'b0;
    logic [7:0]  cmd_code = 8'h00;
    logic [31:0] cmd_wdata = 32'h0000_0000;
    logic [31:0] rd_data;
    logic        rd_valid;
    logic [1:0]  plug = 2'h0, oc = 2'h0, fault = 2'h0, wake = 2'h0;
    logic [1:0]  att, slow, ocl, flt, bus_rst, bus_rsm, pwr;
    int          err_count = 0;
    int          comparisons = 0;
    logic [15:0] rst_len;
    localparam int TB_RST_CYC = 20;

    always #20 clk = ~clk;

    // Port 2 carries a low-speed device so the speed bit is seen in both states
    rhp_usb_dev_model #(.P_SLOW(2'h2)) dev_u (.i_sys_clk(clk), .i_plug(plug), .i_oc_req(oc),
        .i_fault_req(fault), .i_bus_reset(bus_rst), .o_attached(att),
        .o_slow_device(slow), .o_overcurrent(ocl), .o_port_fault(flt), .o_rst_len(rst_len));

    rhp_port_flags #(.P_RST_CYC(TB_RST_CYC), .P_RSM_CYC(30), .P_RSYNC_CYC(10)) dut_u (
        .i_sys_clk(clk), .i_rst(rst), .i_cmd_valid(cmd_valid), .i_cmd_code(cmd_code),
        .i_cmd_wdata(cmd_wdata), .o_rd_data(rd_data), .o_rd_valid(rd_valid),
        .i_attached(att), .i_slow_device(slow), .i_overcurrent(ocl),
        .i_port_fault(flt), .i_remote_wake(wake), .o_bus_reset(bus_rst),
        .o_bus_resume(bus_rsm), .o_port_power(pwr));

    task automatic print_verdict;
        if (err_count == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cmd(input logic [7:0] code, input logic [31:0] data);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_code  = code;
        cmd_wdata = data;
        @(negedge clk);
        cmd_valid = 1'b0;
        cmd_wdata = 32'h0000_0000;
    endtask

    // The valid pulse stands only for the cycle after the taking edge, so look at the next fall
    task automatic rd(input bit p2, input logic [31:0] exp);
        cmd(p2 ? rhp_pkg::CMD_RD_P2 : rhp_pkg::CMD_RD_P1, 32'h0000_0000);
        chk({31'h0, rd_valid}, 32'h1);
        chk(rd_data, exp);
    endtask

    task automatic wr(input bit p2, input logic [31:0] data);
        cmd(p2 ? rhp_pkg::CMD_WR_P2 : rhp_pkg::CMD_WR_P1, data);
    endtask

    task automatic wait_low(input bit rsm);
        int n;
        for (n = 0; n < 2000 && (rsm ? bus_rsm[0] : bus_rst[0]) !== 1'b0; n++) begin
            @(negedge clk);
        end
        if (n == 2000) begin
            err_count++;
            print_verdict();
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask

    initial begin
        repeat (4) @(negedge clk);
        rst = 1'b0;
        rd(0, 32'h0000_0000);
        rd(1, 32'h0000_0000);
        cmd(8'h14, 32'h0000_0000);
        #1 chk({31'h0, rd_valid}, 32'h0);
        plug[0] = 1'b1;
        idle(3);
        rd(0, 32'h0001_0001);
        rd(1, 32'h0000_0000);
        wr(0, 32'h0000_0000);
        rd(0, 32'h0001_0001);
        wr(0, 32'h0001_0000);
        rd(0, 32'h0000_0001);
        wr(1, 32'h0000_0010);
        rd(1, 32'h0001_0000);
        chk({30'h0, bus_rst}, 32'h0);
        wr(0, 32'h0000_0010);
        chk({30'h0, bus_rst}, 32'h1);
        rd(0, 32'h0000_0011);
        wait_low(0);
        chk({16'h0000, rst_len}, TB_RST_CYC);
        idle(3);
        rd(0, 32'h0010_0003);
        wr(0, 32'h0010_0000);
        rd(0, 32'h0000_0003);
        oc[0] = 1'b1;
        idle(3);
        rd(0, 32'h0008_000b);
        wr(0, 32'h0008_0000);
        oc[0] = 1'b0;
        idle(3);
        rd(0, 32'h0008_0003);
        wr(0, 32'h0008_0000);
        wr(0, 32'h0000_0004);
        rd(0, 32'h0000_0007);
        wr(0, 32'h0000_0008);
        chk({30'h0, bus_rsm}, 32'h1);
        wait_low(1);
        idle(20);
        rd(0, 32'h0000_0007);
        idle(40);
        rd(0, 32'h0004_0003);
        wr(0, 32'h0000_0010);
        idle(2);
        wait_low(0);
        idle(3);
        rd(0, 32'h0010_0003);
        wr(0, 32'h0010_0001);
        rd(0, 32'h0000_0001);
        wr(0, 32'h0000_0002);
        fault[0] = 1'b1;
        @(negedge clk);
        fault[0] = 1'b0;
        idle(2);
        rd(0, 32'h0002_0001);
        rd(1, 32'h0001_0000);
        plug[1] = 1'b1;
        idle(3);
        rd(1, 32'h0001_0201);
        rd(0, 32'h0002_0001);
        wr(0, 32'h0002_0102);
        chk({30'h0, pwr}, 32'h1);
        wr(0, 32'h0000_0004);
        wake[0] = 1'b1;
        @(negedge clk);
        wake[0] = 1'b0;
        chk({30'h0, bus_rsm}, 32'h1);
        wait_low(1);
        idle(50);
        rd(0, 32'h0004_0103);
        wr(0, 32'h0004_0200);
        rd(0, 32'h0000_0003);
        chk({30'h0, pwr}, 32'h0);
        print_verdict();
    end
endmodule

`default_nettype wire
